// >>> design/checksum_defines.svh
`ifndef CHECKSUM_DEFINES_SVH
`define CHECKSUM_DEFINES_SVH

// Highest user-addressable program location
`define LAST_USER_ADDR 11'h3fe
// Calibration word, exempt from protection masking
`define CAL_ADDR 11'h3ff
// Mask applied to the configuration word
`define CFG_MASK 14'h01ff
// Position of the active-low program protect bit
`define PROTECT_BIT 7
// Nibble kept from each ID location
`define ID_NIBBLE_MASK 14'h000f
// Accumulator reset value
`define SUM_RESET 16'h0000
// FIFO depth in words
`define FIFO_DEPTH 8

`endif

// >>> design/checksum_pkg.sv
package checksum_pkg;
   typedef logic [13:0] word_t;
   typedef logic [15:0] sum_t;
   typedef logic [10:0] addr_t;
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_prog = 2'b01,
      st_ids = 2'b10,
      st_done = 2'b11
   } phase_e;
endpackage

// >>> design/program_image_checksum.sv
// Behaviour
// - Add program words 0..0x3fe, 16-bit sum, carries out of bit 15 dropped.
// - Unprotected: sum of program words plus config word masked with 0x01ff.
// - Protected: masked config word plus packed ID value, no program words.
// - Packed ID: low nibble of each ID location, first location on top.
// - Config word and ID locations enter the sum in clear form always.
// - Protected device reads every program word but 0x3ff as zero; read_back never shows this, as protected runs take no program words.
`timescale 1ns/100ps
`default_nettype none
`include "checksum_defines.svh"
module program_image_checksum (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic start,
   input wire checksum_pkg::word_t config_word_term,
   input wire logic word_valid,
   output logic word_ready,
   input wire checksum_pkg::word_t word_data,
   output logic busy,
   output logic done,
   output checksum_pkg::sum_t checksum,
   output checksum_pkg::word_t read_back
);
   import checksum_pkg::*;

   // =====================================
   // Input buffering
   logic fifo_out_valid, fifo_out_ready, fifo_in_ready;
   logic start_taken;
   word_t fifo_out_data;

   // Flushed only by an accepted start, so stray starts keep words
   word_fifo #(.WIDTH(14), .DEPTH(`FIFO_DEPTH)) u_fifo (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .flush(start_taken),
      .in_valid(word_valid && word_ready),
      .in_ready(fifo_in_ready),
      .in_data(word_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // =====================================
   // Sequencer state
   phase_e phase, next_phase;
   addr_t addr, next_addr;
   logic [1:0] id_idx, next_id_idx;
   sum_t acc, next_acc;
   word_t cfg, next_cfg;
   logic protect_on, next_protect_on;
   sum_t next_checksum;
   logic next_done, next_busy, next_word_ready;
   word_t next_read_back;
   sum_t cfg_masked, id_nibble;
   logic take;

   // A start while busy is refused and must not flush live words
   assign start_taken = start && ((phase == st_idle) || (phase == st_done));

   // Fixed expected word count keeps the host stream simple
   always_comb begin
      next_phase = phase;
      next_addr = addr;
      next_id_idx = id_idx;
      next_acc = acc;
      next_cfg = cfg;
      next_protect_on = protect_on;
      next_checksum = checksum;
      next_done = 1'b0;
      next_read_back = read_back;
      cfg_masked = {2'b00, cfg & `CFG_MASK};
      id_nibble = {12'h000, fifo_out_data[3:0]} & {2'b00, `ID_NIBBLE_MASK};
      take = fifo_out_valid &&
         ((phase == st_prog) || (phase == st_ids));
      case (phase)
         st_idle, st_done: begin
            if (start) begin
               next_acc = `SUM_RESET;
               next_addr = '0;
               next_id_idx = '0;
               next_cfg = config_word_term;
               // Active-low bit: zero means protected
               next_protect_on = !config_word_term[`PROTECT_BIT];
               next_phase = config_word_term[`PROTECT_BIT] ? st_prog : st_ids;
            end
         end
         st_prog: begin
            if (take) begin
               // Wraps naturally at 16 bits
               next_acc = acc + {2'b00, fifo_out_data};
               next_addr = addr + 11'h001;
               // Show the word as a protected part would return it
               next_read_back = (protect_on && addr != `CAL_ADDR) ?
                  14'h0000 : fifo_out_data;
               if (addr == `LAST_USER_ADDR) begin
                  next_checksum = acc + {2'b00, fifo_out_data}
                     + cfg_masked;
                  next_done = 1'b1;
                  next_phase = st_done;
               end
            end
         end
         st_ids: begin
            if (take) begin
               // First ID lands in the top nibble
               next_acc = {acc[11:0], id_nibble[3:0]};
               next_id_idx = id_idx + 2'b01;
               if (id_idx == 2'b11) begin
                  next_checksum = {acc[11:0], id_nibble[3:0]}
                     + cfg_masked;
                  next_done = 1'b1;
                  next_phase = st_done;
               end
            end
         end
         default: next_phase = st_idle;
      endcase
      next_busy = (next_phase == st_prog) || (next_phase == st_ids);
      next_word_ready = next_busy;
   end

   // Drain one word a cycle; the buffer absorbs the registered ready lag
   assign fifo_out_ready = (phase == st_prog) || (phase == st_ids);

   // =====================================
   // Registered state and outputs
   // Every top-level output leaves from this process
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         phase <= st_idle;
         addr <= '0;
         id_idx <= '0;
         acc <= `SUM_RESET;
         cfg <= '0;
         protect_on <= 1'b0;
         checksum <= `SUM_RESET;
         done <= 1'b0;
         busy <= 1'b0;
         word_ready <= 1'b0;
         read_back <= '0;
      end else begin
         phase <= next_phase;
         addr <= next_addr;
         id_idx <= next_id_idx;
         acc <= next_acc;
         cfg <= next_cfg;
         protect_on <= next_protect_on;
         checksum <= next_checksum;
         done <= next_done;
         busy <= next_busy;
         word_ready <= next_word_ready && fifo_in_ready;
         read_back <= next_read_back;
      end
   end

   // =====================================
   // Checks
   // Final unprotected word yields the words plus the masked config
   prog_sum_a: assert property (@(posedge ref_clk)
      disable iff (!arst_n)
      (phase == st_prog && take && addr == `LAST_USER_ADDR) |=>
      done && checksum == $past(acc) + {2'b00, $past(fifo_out_data)}
      + $past(cfg_masked)) else $error("bad unprotected sum");
   acc_wrap_a: assert property (@(posedge ref_clk)
      disable iff (!arst_n)
      (phase == st_prog && take) |=>
      acc == $past(acc) + {2'b00, $past(fifo_out_data)})
      else $error("accumulator step wrong");
   id_pack_a: assert property (@(posedge ref_clk)
      disable iff (!arst_n)
      (phase == st_ids && take) |=>
      acc[3:0] == $past(fifo_out_data[3:0]))
      else $error("id nibble not packed");
   prot_sum_a: assert property (@(posedge ref_clk)
      disable iff (!arst_n)
      (phase == st_ids && take && id_idx == 2'b11) |=>
      done && checksum == {$past(acc[11:0]), $past(fifo_out_data[3:0])}
      + $past(cfg_masked)) else $error("bad protected sum");
   // Protected runs leave the program address counter alone
   no_prog_word_a: assert property (@(posedge ref_clk)
      disable iff (!arst_n)
      (phase == st_ids) |=> $stable(addr))
      else $error("program word counted");
   start_clear_a: assert property (@(posedge ref_clk)
      disable iff (!arst_n)
      (start && (phase == st_idle || phase == st_done)) |=>
      acc == `SUM_RESET && busy) else $error("start failed");
   formula_sel_a: assert property (@(posedge ref_clk)
      disable iff (!arst_n)
      (start && phase != st_prog && phase != st_ids
      && !config_word_term[`PROTECT_BIT]) |=> phase == st_ids)
      else $error("wrong formula chosen");
   // A stray start while collecting must not reload the run
   stray_start_a: assert property (@(posedge ref_clk)
      disable iff (!arst_n)
      (start && (phase == st_prog || phase == st_ids)) |=>
      $stable(cfg) && $stable(protect_on))
      else $error("busy start taken");
   // Words of an open part are shown as read, never blanked
   zero_read_a: assert property (@(posedge ref_clk)
      disable iff (!arst_n)
      (phase == st_prog && take && !protect_on) |=>
      read_back == $past(fifo_out_data))
      else $error("read back wrong");
   cfg_mask_a: assert property (@(posedge ref_clk)
      disable iff (!arst_n)
      cfg_masked == {7'h00, cfg[8:0]})
      else $error("mask wrong");
   done_pulse_a: assert property (@(posedge ref_clk)
      disable iff (!arst_n)
      done |=> !done) else $error("done not a pulse");
   // The result is flagged only once collection has stopped
   done_idle_a: assert property (@(posedge ref_clk)
      disable iff (!arst_n)
      done |-> !busy && !word_ready) else $error("done while busy");
   ready_busy_a: assert property (@(posedge ref_clk)
      disable iff (!arst_n)
      word_ready |-> busy) else $error("ready while idle");

   // Main scenarios worth seeing at least once
   unprot_run_c: cover property (@(posedge ref_clk) disable iff (!arst_n)
      phase == st_prog ##1 done);
   prot_run_c: cover property (@(posedge ref_clk) disable iff (!arst_n)
      phase == st_ids ##1 done);
   source_stall_c: cover property (@(posedge ref_clk) disable iff (!arst_n)
      busy && word_ready && !word_valid);
   stray_start_c: cover property (@(posedge ref_clk) disable iff (!arst_n)
      start && busy);
endmodule // program_image_checksum
`default_nettype wire

// >>> design/word_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module word_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 8
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0] count, next_count;
   logic push, pop;

   // =====================================
   // Occupancy
   always_comb begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      if (flush) begin
         next_wr_ptr = '0;
         next_rd_ptr = '0;
         next_count = '0;
      end
   end

   assign in_ready = (count != DEPTH[AW:0]);
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   // Storage has no reset; only written words are read
   always_ff @(posedge ref_clk) begin
      if (push && !flush) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule // word_fifo
`default_nettype wire

// >>> testbench/program_image_checksum_tb.sv
`timescale 1ns/100ps
`default_nettype none
module program_image_checksum_tb;
   import checksum_pkg::*;
   typedef struct {word_t cfg; word_t seed; logic slow;} row_s;
   logic ref_clk, arst_n, start, go, slow, word_valid, word_ready;
   logic busy, done;
   word_t cfg, seed, word_data, read_back;
   sum_t checksum;
   int fail_count = 0;
   int compares = 0;
   // Bit 7 low selects the protected formula; bit 8 tests the mask
   row_s rows [4] = '{
      '{14'h3fff, 14'h3fff, 1'b0},
      '{14'h2eda, 14'h0123, 1'b1},
      '{14'h3f7f, 14'h1ad3, 1'b0},
      '{14'h0000, 14'h3ff1, 1'b1}};

   program_image_checksum i_dut (.ref_clk(ref_clk), .arst_n(arst_n),
      .start(start), .config_word_term(cfg), .word_valid(word_valid),
      .word_ready(word_ready), .word_data(word_data), .busy(busy),
      .done(done), .checksum(checksum), .read_back(read_back));
   word_source i_src (.ref_clk(ref_clk), .go(go), .prot(~cfg[7]),
      .slow(slow), .seed(seed), .word_ready(word_ready),
      .word_valid(word_valid), .word_data(word_data));

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // =========================================
   // Reference sum and comparison helpers
   function automatic sum_t expect_sum(word_t c, word_t s);
      sum_t acc;
      word_t w;
      acc = 16'(c & 14'h01ff);
      for (int i = 0; i < (c[7] ? 1023 : 4); i++) begin
         w = 14'(i * s + s);
         // Carries past bit 15 fall away in the 16-bit add
         if (c[7]) acc = acc + 16'(w);
         else acc = acc + (16'(w[3:0]) << (12 - 4 * i));
      end
      return acc;
   endfunction

   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("Counts: %0d compares, %0d mismatches", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // One checksum; a probe raises a stray start while busy
   task automatic run(row_s r, logic probe);
      int n;
      word_t lw;
      @(posedge ref_clk);
      #1;
      cfg = r.cfg;
      seed = r.seed;
      slow = r.slow;
      start = 1'b1;
      go = 1'b1;
      @(posedge ref_clk);
      #1;
      start = 1'b0;
      go = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 3000) begin
         @(posedge ref_clk);
         #1;
         start = probe && n == 3;
         if (start) cfg = ~cfg;
         n++;
      end
      start = 1'b0;
      if (n >= 3000) begin
         fail_count++;
         $display("Timeout waiting for done");
         wrap_up();
      end
      check("checksum", checksum, expect_sum(r.cfg, r.seed));
      check("busy", 16'(busy), 16'h0000);
      // Last program word of an open part is shown as read
      lw = 14'(1022 * r.seed + r.seed);
      if (r.cfg[7]) check("read_back", 16'(read_back), 16'(lw));
      @(posedge ref_clk);
      #1;
      check("done", 16'(done), 16'h0000);
      check("held", checksum, expect_sum(r.cfg, r.seed));
      $display("Test cfg %h seed %h ended", r.cfg, r.seed);
   endtask

   // =========================================
   // Table rows, stray start, reset mid-run
   initial begin
      arst_n = 1'b0;
      start = 1'b0;
      go = 1'b0;
      slow = 1'b0;
      cfg = 14'h0000;
      seed = 14'h0000;
      repeat (3) @(posedge ref_clk);
      #1 arst_n = 1'b1;
      foreach (rows[i]) run(rows[i], 1'b0);
      run(rows[0], 1'b1);
      cfg = rows[2].cfg;
      start = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1 start = 1'b0;
      check("busy", 16'(busy), 16'h0001);
      arst_n = 1'b0;
      #1;
      check("busy", 16'(busy), 16'h0000);
      check("checksum", checksum, 16'h0000);
      check("read_back", 16'(read_back), 16'h0000);
      // Release again and prove a full run still works afterwards
      @(posedge ref_clk);
      #1 arst_n = 1'b1;
      run(rows[3], 1'b0);
      $display("Test reset ended");
      wrap_up();
   end
endmodule // program_image_checksum_tb
`default_nettype wire

// >>> testbench/word_source.sv
`timescale 1ns/100ps
`default_nettype none
// =========================================
// Programmer feeding words to the checksum
module word_source (
   input wire logic ref_clk,
   input wire logic go,
   input wire logic prot,
   input wire logic slow,
   input wire logic [13:0] seed,
   input wire logic word_ready,
   output logic word_valid,
   output logic [13:0] word_data
);
   int idx;
   int total;
   int wait_n;
   // Words as read back from the part, held until taken
   initial begin
      word_valid = 1'b0;
      word_data = 14'h0000;
      forever begin
         @(posedge ref_clk);
         if (go) begin
            total = prot ? 4 : 1023;
            for (idx = 0; idx < total; idx++) begin
               #1;
               word_valid = 1'b1;
               word_data = 14'(idx * seed + seed);
               // Bounded wait; a stuck ready is caught by the bench timeout
               wait_n = 0;
               do begin
                  @(posedge ref_clk);
                  wait_n++;
               end while (word_ready !== 1'b1 && wait_n < 4000);
               // Stalls leave a changed value, never a stale one
               if (slow || idx == total - 1) begin
                  #1;
                  word_valid = 1'b0;
                  word_data = ~word_data;
                  @(posedge ref_clk);
               end
            end
         end
      end
   end
endmodule // word_source
`default_nettype wire
